// ==== rtl/phy_an_regs_pkg.sv ====
// Constants for the partner ability, expansion and vendor control registers.
// Assumes a 16-bit management register path with 5-bit register addresses.
package phy_an_regs_pkg;
    localparam logic [4:0] partner_ability_addr = 5'h05;
    localparam logic [4:0] expansion_addr = 5'h06;
    localparam logic [4:0] vendor_control_addr = 5'h10;
    localparam logic [15:0] partner_ability_reset = 16'h0000;
    localparam logic [15:0] expansion_reset = 16'h0000;
    localparam logic [15:0] vendor_control_reset = 16'h0140;
    // Reserved bits 13, 9:6 and 3:2 of the vendor register read this fixed value
    localparam logic [15:0] vendor_fixed_mask = 16'h23cc;
    localparam logic [15:0] vendor_fixed_value = 16'h0140;
    localparam int next_page_bit = 15;
    localparam int ack_bit = 14;
    localparam int remote_fault_bit = 13;
    localparam int tech_msb = 12;
    localparam int tech_lsb = 5;
    localparam int sel_msb = 4;
    localparam int sel_lsb = 0;
    localparam int auto_polarity_disable_bit = 5;
    localparam int receive_inversion_bit = 4;
    localparam int bypass_bit = 1;
    localparam int clock_gating_bit = 0;
    localparam logic [4:0] sel_8023 = 5'h01;
    localparam logic [4:0] sel_8029 = 5'h02;
    localparam logic [4:0] sel_8025 = 5'h03;
    localparam logic [4:0] sel_1394 = 5'h04;
endpackage : phy_an_regs_pkg

// ==== rtl/page_store.sv ====
// Holds the last base page received from the link partner.
// Assumes page_valid is a one-cycle pulse on mclk.
`timescale 1ns/10ps
module page_store
    import phy_an_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic page_valid,
    input wire logic [15:0] page_word,
    output logic [15:0] rd_data
);
    logic [15:0] page_ff;

    // Only a newly received page changes the contents; see R13
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            page_ff <= partner_ability_reset; // see R1
        end else if (page_valid) begin
            page_ff <= page_word; // see R2 see R4 see R5 see R6
        end
    end

    assign rd_data = page_ff;
endmodule : page_store

// ==== rtl/phy_autoneg_partner_vendor_regs.sv ====
// Partner ability, expansion and vendor control management registers.
// Assumes a single-cycle register access port on mclk and status from the PHY core.
//
// Contract
// R1 - Partner ability register at 0x05, read-only, resets to zero.
// R2 - Bit 15 reads one when partner is next-page capable.
// R3 - Bit 14 set once partner abilities are received successfully.
// R4 - Bit 13 carries the partner's remote fault indication.
// R5 - Bits 12:5 hold received technology ability field.
// R6 - Bits 4:0 hold received selector; codes 0 and 5-1f reserved.
// R7 - Expansion register at 0x06, read-only, resets to zero.
// R8 - Vendor control at 0x10, writable, resets to 0x0140, reserved bits fixed.
// R9 - Bit 5 set disables automatic receive polarity correction.
// R10 - Bit 4 shows inversion; writable and forces inversion when auto-polarity off.
// R11 - Bit 1 bypasses coding and scrambler in 100BASE-TX without autoneg.
// R12 - Bit 0 gates receive clock when idle; off under loopback or bypass. Code also keeps gating off unless speed_100tx is set.
// R13 - Writes to read-only registers ignored; partner page changes only on new page.
`timescale 1ns/10ps
module phy_autoneg_partner_vendor_regs
    import phy_an_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_hit,
    input wire logic page_rx_valid,
    input wire logic page_rx_next_page,
    input wire logic page_rx_remote_fault,
    input wire logic [7:0] page_rx_tech,
    input wire logic [4:0] page_rx_sel,
    input wire logic [15:0] expansion_status,
    input wire logic polarity_wrong,
    input wire logic autoneg_enable,
    input wire logic speed_100tx,
    input wire logic loopback_select,
    output logic receive_inversion,
    output logic coding_bypass,
    output logic receive_clock_gating,
    output logic auto_polarity_disable
);
    logic [15:0] vendor_ff;
    logic [15:0] expansion_ff;
    logic [15:0] reg_rdata_ff;
    logic reg_hit_ff;
    logic inv_ff;
    logic bypass_ff;
    logic gate_ff;
    logic [15:0] partner_word;
    logic [15:0] partner_rd;
    logic [15:0] page_word;
    logic nxt_inv;
    logic vendor_wr;
    logic [15:0] nxt_vendor;
    logic nxt_bypass;
    logic nxt_gate;
    logic [15:0] nxt_rdata;
    logic nxt_hit;

    // Reserved bits forced on the way in and on the way out; see R8
    function automatic logic [15:0] vendor_fix(input logic [15:0] v);
        return (v & ~vendor_fixed_mask) | vendor_fixed_value;
    endfunction : vendor_fix

    function automatic logic [15:0] vendor_view(input logic [15:0] v, input logic inv);
        logic [15:0] r;
        r = vendor_fix(v); // see R8
        r[receive_inversion_bit] = inv; // see R10
        return r;
    endfunction : vendor_view

    // One decode for every mapped address
    function automatic logic addr_mapped(input logic [4:0] a);
        return (a == partner_ability_addr) || (a == expansion_addr) || (a == vendor_control_addr);
    endfunction : addr_mapped

    // Acknowledge comes from the fact of a reception, not from the page; see R3
    function automatic logic [15:0] pack_page(input logic next_page, input logic fault, input logic [7:0] tech,
        input logic [4:0] sel);
        logic [15:0] p;
        p = 16'h0000;
        p[next_page_bit] = next_page; // see R2
        p[ack_bit] = 1'b1; // see R3
        p[remote_fault_bit] = fault; // see R4
        p[tech_msb:tech_lsb] = tech; // see R5
        p[sel_msb:sel_lsb] = sel; // see R6
        return p;
    endfunction : pack_page

    assign page_word = pack_page(page_rx_next_page, page_rx_remote_fault, page_rx_tech, page_rx_sel);

    page_store u_page_store (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .page_valid(page_rx_valid),
        .page_word(page_word),
        .rd_data(partner_rd)
    );
    assign partner_word = partner_rd;

    // Expansion contents come from the negotiation core only; see R7
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            expansion_ff <= expansion_reset;
        end else begin
            expansion_ff <= expansion_status;
        end
    end

    // Only the vendor register accepts writes; see R13
    assign vendor_wr = reg_wr && (reg_addr == vendor_control_addr);

    always_comb begin
        if (vendor_wr) begin
            nxt_vendor = vendor_fix(reg_wdata); // see R8
        end else begin
            nxt_vendor = vendor_ff;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            vendor_ff <= vendor_control_reset; // see R8
        end else begin
            vendor_ff <= nxt_vendor;
        end
    end

    // Auto-polarity follows the detector; forced inversion follows the stored bit
    always_comb begin
        if (vendor_ff[auto_polarity_disable_bit]) begin
            nxt_inv = vendor_ff[receive_inversion_bit]; // see R10
        end else begin
            nxt_inv = polarity_wrong; // see R9
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            inv_ff <= 1'b0;
        end else begin
            inv_ff <= nxt_inv;
        end
    end

    // Bypass is honoured only in its one valid configuration
    always_comb begin
        if (autoneg_enable || !speed_100tx) begin
            nxt_bypass = 1'b0; // see R11
        end else begin
            nxt_bypass = vendor_ff[bypass_bit]; // see R11
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            bypass_ff <= 1'b0;
        end else begin
            bypass_ff <= nxt_bypass;
        end
    end

    // Next bypass value used so gating never pulses while bypass arms
    always_comb begin
        if (loopback_select || nxt_bypass) begin
            nxt_gate = 1'b0; // see R12
        end else begin
            nxt_gate = vendor_ff[clock_gating_bit] && speed_100tx; // see R12
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gate_ff <= 1'b0;
        end else begin
            gate_ff <= nxt_gate;
        end
    end

    // Unmapped addresses read zero with the hit flag low
    always_comb begin
        nxt_rdata = 16'h0000;
        nxt_hit = addr_mapped(reg_addr);
        unique case (reg_addr)
            partner_ability_addr: begin
                nxt_rdata = partner_word; // see R1
            end
            expansion_addr: begin
                nxt_rdata = expansion_ff; // see R7
            end
            vendor_control_addr: begin
                nxt_rdata = vendor_view(vendor_ff, inv_ff); // see R10
            end
            default: begin
                nxt_rdata = 16'h0000;
            end
        endcase
    end

    // Data holds between reads, so a late look still finds it
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata_ff <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    // One-cycle hit per mapped read
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_hit_ff <= 1'b0;
        end else begin
            reg_hit_ff <= reg_rd && nxt_hit;
        end
    end

    assign reg_rdata = reg_rdata_ff;
    assign reg_hit = reg_hit_ff;
    assign receive_inversion = inv_ff;
    assign coding_bypass = bypass_ff;
    assign receive_clock_gating = gate_ff;
    assign auto_polarity_disable = vendor_ff[auto_polarity_disable_bit]; // see R9
endmodule : phy_autoneg_partner_vendor_regs

// ==== sim/link_partner_model.sv ====
// Link partner model: sends base pages as one-cycle pulses.
// Assumes mclk comes from the bench.
`timescale 1ns/10ps
module link_partner_model (
    input wire logic mclk,
    output logic page_rx_valid,
    output logic page_rx_next_page,
    output logic page_rx_remote_fault,
    output logic [7:0] page_rx_tech,
    output logic [4:0] page_rx_sel
);
    initial begin
        page_rx_valid = 1'b0;
        {page_rx_next_page, page_rx_remote_fault, page_rx_tech, page_rx_sel} = 15'h0000;
    end
    task send(input logic [15:0] w);
        @(posedge mclk) #1;
        page_rx_valid = 1'b1;
        {page_rx_next_page, page_rx_remote_fault, page_rx_tech, page_rx_sel} = {w[15], w[13:0]};
        @(posedge mclk) #1;
        page_rx_valid = 1'b0;
        // Stale fields inverted so a late sample shows up
        {page_rx_next_page, page_rx_remote_fault, page_rx_tech, page_rx_sel} = ~{w[15], w[13:0]};
    endtask : send
endmodule : link_partner_model

// ==== sim/phy_autoneg_partner_vendor_regs_assertions.sv ====
// Checker for the partner, expansion and vendor registers.
// Sees only top-level ports; bound below.
`timescale 1ns/10ps
module phy_an_regs_chk
    import phy_an_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_hit,
    input wire logic polarity_wrong,
    input wire logic autoneg_enable,
    input wire logic speed_100tx,
    input wire logic loopback_select,
    input wire logic receive_inversion,
    input wire logic coding_bypass,
    input wire logic receive_clock_gating,
    input wire logic auto_polarity_disable
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    logic map_rd;
    assign map_rd = reg_rd && (reg_addr inside {partner_ability_addr, expansion_addr, vendor_control_addr});
    sequence vend_rd;
        reg_rd && !reg_wr && reg_addr == vendor_control_addr;
    endsequence
    chk_hit_mapped: assert property (map_rd |=> reg_hit) else $error("no hit");
    chk_hit_cause: assert property (!map_rd |=> !reg_hit) else $error("stray hit");
    chk_unmapped_zero: assert property (reg_rd && !map_rd |=> reg_rdata == 16'h0000)
        else $error("unmapped data");
    chk_fixed_bits: assert property (vend_rd |=> (reg_rdata & vendor_fixed_mask) == vendor_fixed_value)
        else $error("fixed bits");
    chk_pol_disable_read: assert property (vend_rd |=>
        reg_rdata[auto_polarity_disable_bit] == auto_polarity_disable) else $error("polarity disable readback");
    chk_gate_bypass_excl: assert property (!(receive_clock_gating && coding_bypass))
        else $error("gating with bypass");
    chk_bypass_cond: assert property (coding_bypass |-> $past(!autoneg_enable && speed_100tx))
        else $error("bypass cond");
    chk_gate_cond: assert property (receive_clock_gating |-> $past(speed_100tx && !loopback_select))
        else $error("gating cond");
    chk_auto_pol: assert property (!$past(sys_rst) && !$past(auto_polarity_disable)
        |-> receive_inversion == $past(polarity_wrong)) else $error("auto polarity");
endmodule : phy_an_regs_chk

bind phy_autoneg_partner_vendor_regs phy_an_regs_chk chk_u (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .reg_rd(reg_rd),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_rdata(reg_rdata),
    .reg_hit(reg_hit),
    .polarity_wrong(polarity_wrong),
    .autoneg_enable(autoneg_enable),
    .speed_100tx(speed_100tx),
    .loopback_select(loopback_select),
    .receive_inversion(receive_inversion),
    .coding_bypass(coding_bypass),
    .receive_clock_gating(receive_clock_gating),
    .auto_polarity_disable(auto_polarity_disable)
);

// ==== sim/phy_autoneg_partner_vendor_regs_tb_top.sv ====
// Bench for the partner, expansion and vendor registers.
// Assumes the link partner model and the bound checker.
`timescale 1ns/10ps
module phy_autoneg_partner_vendor_regs_tb_top
    import phy_an_regs_pkg::*;
;
    logic mclk, sys_rst, reg_rd, reg_wr, reg_hit, page_rx_valid, page_rx_next_page, page_rx_remote_fault;
    logic polarity_wrong, autoneg_enable, speed_100tx, loopback_select;
    logic receive_inversion, coding_bypass, receive_clock_gating, auto_polarity_disable;
    logic [4:0] reg_addr, page_rx_sel;
    logic [7:0] page_rx_tech;
    logic [15:0] reg_wdata, reg_rdata, expansion_status, w;
    int errors, cmp_count;
    link_partner_model lp_u (
        .mclk(mclk),
        .page_rx_valid(page_rx_valid),
        .page_rx_next_page(page_rx_next_page),
        .page_rx_remote_fault(page_rx_remote_fault),
        .page_rx_tech(page_rx_tech),
        .page_rx_sel(page_rx_sel)
    );
    phy_autoneg_partner_vendor_regs dut_u (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .reg_rd(reg_rd),
        .reg_wr(reg_wr),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_hit(reg_hit),
        .page_rx_valid(page_rx_valid),
        .page_rx_next_page(page_rx_next_page),
        .page_rx_remote_fault(page_rx_remote_fault),
        .page_rx_tech(page_rx_tech),
        .page_rx_sel(page_rx_sel),
        .expansion_status(expansion_status),
        .polarity_wrong(polarity_wrong),
        .autoneg_enable(autoneg_enable),
        .speed_100tx(speed_100tx),
        .loopback_select(loopback_select),
        .receive_inversion(receive_inversion),
        .coding_bypass(coding_bypass),
        .receive_clock_gating(receive_clock_gating),
        .auto_polarity_disable(auto_polarity_disable)
    );
    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge mclk) #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge mclk) #1;
        reg_rd = 1'b0;
        chk(reg_rdata, e);
        chk({15'h0000, reg_hit}, {15'h0000, a inside {5'h05, 5'h06, 5'h10}});
    endtask : rd
    task wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk) #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge mclk) #1;
        reg_wr = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask : wr
    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        #50000;
        errors++;
        summarize();
    end
    initial begin
        {sys_rst, reg_rd, reg_wr, polarity_wrong, autoneg_enable, speed_100tx, loopback_select} = 7'h40;
        {reg_addr, reg_wdata, expansion_status} = 37'h0;
        repeat (3) @(posedge mclk);
        #1 sys_rst = 1'b0;
        rd(partner_ability_addr, 16'h0000);
        rd(expansion_addr, 16'h0000);
        rd(vendor_control_addr, 16'h0140);
        rd(5'h07, 16'h0000);
        $display("test reset done");
        expansion_status = 16'h000b;
        wr(expansion_addr, 16'hffff);
        rd(expansion_addr, 16'h000b);
        // Reserved selectors too: the store must not filter them
        for (int i = 0; i < 6; i++) begin
            w = {i[0], 1'b0, i[1], 8'h5a ^ i[7:0], (i == 5) ? 5'h1f : i[4:0]};
            lp_u.send(w);
            rd(partner_ability_addr, w | 16'h4000);
        end
        wr(partner_ability_addr, 16'h0000);
        rd(partner_ability_addr, w | 16'h4000);
        $display("test pages done");
        {polarity_wrong, speed_100tx} = 2'h3;
        wr(vendor_control_addr, 16'hffff);
        rd(vendor_control_addr, 16'hdd73);
        chk({coding_bypass, receive_clock_gating, receive_inversion}, 16'h0005);
        wr(vendor_control_addr, 16'h0021);
        rd(vendor_control_addr, 16'h0161);
        chk({coding_bypass, receive_clock_gating, receive_inversion}, 16'h0002);
        loopback_select = 1'b1;
        wr(vendor_control_addr, 16'h0003);
        chk({receive_clock_gating, auto_polarity_disable}, 16'h0000);
        autoneg_enable = 1'b1;
        wr(vendor_control_addr, 16'h0002);
        rd(vendor_control_addr, 16'h0152);
        chk({coding_bypass, receive_inversion}, 16'h0001);
        $display("test vendor done");
        summarize();
    end
endmodule : phy_autoneg_partner_vendor_regs_tb_top
